// file: logic/hpp_pkg.sv
// Shared constants for the host port page-address block.
// Assumes one 100 MHz clock and an AXI4-Lite register bus with 32-bit data.
package hpp_pkg;

  localparam logic [31:0] HPP_CFG_OFFSET      = 32'h40000008;
  localparam logic [31:0] HPP_PAGE_TOP_OFFSET = 32'h4000000c;
  localparam logic [31:0] HPP_PAGE_MID_OFFSET = 32'h40000010;

  localparam int          HPP_CFG_PAGING_POS   = 1;
  localparam int          HPP_CFG_SEPARATE_POS = 2;
  localparam logic [7:0]  HPP_PAGE_RESET       = 8'h00;
  localparam logic [1:0]  HPP_CFG_RESET        = 2'h0;

  localparam logic [1:0]  HPP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  HPP_RESP_SLVERR = 2'h2;

  localparam logic [1:0]  HPP_SEL_CONTROL   = 2'h0;
  localparam logic [1:0]  HPP_SEL_DATA_INC  = 2'h1;
  localparam logic [1:0]  HPP_SEL_ADDRESS   = 2'h2;
  localparam logic [1:0]  HPP_SEL_DATA_HOLD = 2'h3;

  localparam logic [31:0] HPP_WORD_STEP = 32'h00000004;

  typedef enum logic [2:0] {
    HPP_IDLE     = 3'b000,
    HPP_FETCH    = 3'b001,
    HPP_HOLD     = 3'b010,
    HPP_WRITE    = 3'b011,
    HPP_PREFETCH = 3'b100,
    HPP_ADDR_SET = 3'b101
  } hpp_state_t;

endpackage : hpp_pkg

// file: logic/hpp_host_port.sv
// Host port page-address block with host handshake and read prefetch.
// Assumes pins are asynchronous to mclk and the memory port answers on mclk.
//
// Behaviour
// - The top page byte supplies internal address bits 31 to 24 in separate-address mode and in paged muxed mode.
// - The upper-middle page byte supplies address bits 23 to 16 in the same two modes.
// - Bits 31 to 8 of both page registers are reserved, read as zero here, and software writes only zeros.
// - Auto-incrementing data reads prefetch the next word so a read that hits it needs no memory wait.
// - An auto-incrementing read with an empty prefetch holds ready low until the fetch returns, then drops it after the strobe rises while fetching ahead.
// - Control and address register reads answer directly with no memory access and no ready toggle.
// - Select, half-word and direction controls are latched at the address strobe fall if used, else at the strobe fall.
// - Muxed mode without paging takes a full 32-bit address; with paging only the low 16 bits come from the host.
// - Separate-address mode is selected when its enable is 1 and muxed mode when it is 0.
`timescale 1ns/1ns
module hpp_host_port
  import hpp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        host_chip_select_n,
  input  wire logic [1:0]  host_data_strobe_n,
  input  wire logic        host_address_strobe_n,
  input  wire logic [1:0]  host_register_select,
  input  wire logic        host_halfword_select,
  input  wire logic        host_read_write,
  input  wire logic [15:0] host_address_pins,
  input  wire logic [31:0] host_data_bus_in,
  output logic [31:0]      host_data_bus_out,
  output logic             host_data_bus_oe,
  output logic             host_ready_out,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.
  logic        aw_held_q, w_held_q;
  logic [31:0] aw_addr_q, w_data_q;
  logic [3:0]  w_strb_q;
  logic [7:0]  page_top_byte_q, page_upper_mid_byte_q;
  logic        paging_enable_q, separate_address_enable_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 32'h00000000;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= HPP_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_held_q && w_held_q) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == HPP_CFG_OFFSET || aw_addr_q == HPP_PAGE_TOP_OFFSET ||
                         aw_addr_q == HPP_PAGE_MID_OFFSET) ? HPP_RESP_OKAY : HPP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only the low byte lane is stored; upper bits are reserved.
  always_ff @(posedge mclk) begin
    if (reset) begin
      page_top_byte_q           <= HPP_PAGE_RESET;
      page_upper_mid_byte_q     <= HPP_PAGE_RESET;
      paging_enable_q           <= HPP_CFG_RESET[0];
      separate_address_enable_q <= HPP_CFG_RESET[1];
    end else if (aw_held_q && w_held_q && w_strb_q[0]) begin
      if (aw_addr_q == HPP_PAGE_TOP_OFFSET) page_top_byte_q <= w_data_q[7:0];
      if (aw_addr_q == HPP_PAGE_MID_OFFSET) page_upper_mid_byte_q <= w_data_q[7:0];
      if (aw_addr_q == HPP_CFG_OFFSET) begin
        paging_enable_q           <= w_data_q[HPP_CFG_PAGING_POS];
        separate_address_enable_q <= w_data_q[HPP_CFG_SEPARATE_POS];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= HPP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= HPP_RESP_OKAY;
        unique case (s_axi_araddr)
          HPP_CFG_OFFSET: s_axi_rdata <= {29'h00000000, separate_address_enable_q, paging_enable_q, 1'b0};
          HPP_PAGE_TOP_OFFSET: s_axi_rdata <= {24'h000000, page_top_byte_q};
          HPP_PAGE_MID_OFFSET: s_axi_rdata <= {24'h000000, page_upper_mid_byte_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= HPP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strobe forming.
  logic [1:0]  ds_meta_q, ds_sync_q;
  logic        cs_meta_q, cs_sync_q, as_meta_q, as_sync_q;
  logic        strobe_q, as_prev_q;
  logic [3:0]  ctl_meta_q, ctl_sync_q;
  logic [15:0] pins_meta_q, pins_sync_q;
  logic [31:0] data_meta_q, data_sync_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ds_meta_q   <= 2'h3;
      ds_sync_q   <= 2'h3;
      cs_meta_q   <= 1'b1;
      cs_sync_q   <= 1'b1;
      as_meta_q   <= 1'b1;
      as_sync_q   <= 1'b1;
      ctl_meta_q  <= 4'h0;
      ctl_sync_q  <= 4'h0;
      pins_meta_q <= 16'h0000;
      pins_sync_q <= 16'h0000;
      data_meta_q <= 32'h00000000;
      data_sync_q <= 32'h00000000;
      strobe_q    <= 1'b0;
      as_prev_q   <= 1'b1;
    end else begin
      ds_meta_q   <= host_data_strobe_n;
      ds_sync_q   <= ds_meta_q;
      cs_meta_q   <= host_chip_select_n;
      cs_sync_q   <= cs_meta_q;
      as_meta_q   <= host_address_strobe_n;
      as_sync_q   <= as_meta_q;
      ctl_meta_q  <= {host_register_select, host_halfword_select, host_read_write};
      ctl_sync_q  <= ctl_meta_q;
      pins_meta_q <= host_address_pins;
      pins_sync_q <= pins_meta_q;
      data_meta_q <= host_data_bus_in;
      data_sync_q <= data_meta_q;
      strobe_q    <= !cs_sync_q && (ds_sync_q[0] ^ ds_sync_q[1]);
      as_prev_q   <= as_sync_q;
    end
  end

  logic strobe_now, strobe_fall, strobe_rise, as_fall;
  assign strobe_now  = !cs_sync_q && (ds_sync_q[0] ^ ds_sync_q[1]);
  assign strobe_fall = strobe_now && !strobe_q;
  assign strobe_rise = !strobe_now && strobe_q;
  assign as_fall     = !as_sync_q && as_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Host access engine.
  function automatic logic [31:0] hpp_page_addr(input logic [15:0] low);
    hpp_page_addr = {page_top_byte_q, page_upper_mid_byte_q, low};
  endfunction : hpp_page_addr

  hpp_state_t  state_q;
  logic [3:0]  ctl_q;
  logic        as_used_q;
  logic [31:0] addr_q, control_q, fifo_data_q;
  logic        fifo_valid_q;
  logic [1:0]  sel;
  logic        is_read;
  assign sel     = ctl_q[3:2];
  assign is_read = ctl_q[0];

  // Controls are captured at the address strobe fall, or at the strobe fall without it.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_q     <= 4'h0;
      as_used_q <= 1'b0;
    end else if (as_fall) begin
      ctl_q     <= ctl_sync_q;
      as_used_q <= 1'b1;
    end else if (strobe_fall && !as_used_q) begin
      ctl_q <= ctl_sync_q;
    end else if (strobe_rise) begin
      as_used_q <= 1'b0;
    end
  end

  logic [3:0] cur_ctl;
  assign cur_ctl = (as_used_q || as_fall) ? ctl_q : ctl_sync_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q           <= HPP_IDLE;
      addr_q            <= 32'h00000000;
      control_q         <= 32'h00000000;
      fifo_data_q       <= 32'h00000000;
      fifo_valid_q      <= 1'b0;
      host_ready_out    <= 1'b1;
      host_data_bus_out <= 32'h00000000;
      host_data_bus_oe  <= 1'b0;
      mem_req           <= 1'b0;
      mem_we            <= 1'b0;
      mem_addr          <= 32'h00000000;
      mem_wdata         <= 32'h00000000;
    end else begin
      unique case (state_q)
        HPP_IDLE: begin
          if (strobe_fall && cur_ctl[0]) begin
            host_data_bus_oe <= 1'b1;
            state_q          <= HPP_HOLD;
            unique case (cur_ctl[3:2])
              HPP_SEL_CONTROL: host_data_bus_out <= control_q;
              HPP_SEL_ADDRESS: host_data_bus_out <= addr_q;
              HPP_SEL_DATA_INC: begin
                if (fifo_valid_q) begin
                  host_data_bus_out <= fifo_data_q;
                end else begin
                  host_ready_out <= 1'b0;
                  mem_req        <= 1'b1;
                  mem_we         <= 1'b0;
                  mem_addr       <= addr_q;
                  state_q        <= HPP_FETCH;
                end
              end
              HPP_SEL_DATA_HOLD: begin
                host_ready_out <= 1'b0;
                mem_req        <= 1'b1;
                mem_we         <= 1'b0;
                mem_addr       <= addr_q;
                state_q        <= HPP_FETCH;
              end
            endcase
          end else if (strobe_fall) begin
            state_q <= HPP_HOLD;
          end
        end
        HPP_FETCH: begin
          if (mem_ack) begin
            mem_req           <= 1'b0;
            host_data_bus_out <= mem_rdata;
            host_ready_out    <= 1'b1;
            state_q           <= HPP_HOLD;
          end
        end
        HPP_HOLD: begin
          if (strobe_rise) begin
            host_data_bus_oe <= 1'b0;
            if (is_read && sel == HPP_SEL_DATA_INC) begin
              addr_q         <= addr_q + HPP_WORD_STEP;
              fifo_valid_q   <= 1'b0;
              host_ready_out <= 1'b0;
              mem_req        <= 1'b1;
              mem_we         <= 1'b0;
              mem_addr       <= addr_q + HPP_WORD_STEP;
              state_q        <= HPP_PREFETCH;
            end else if (!is_read && sel == HPP_SEL_ADDRESS) begin
              host_ready_out <= 1'b0;
              fifo_valid_q   <= 1'b0;
              if (separate_address_enable_q) begin
                addr_q <= hpp_page_addr(pins_sync_q);
              end else if (paging_enable_q) begin
                addr_q <= hpp_page_addr(data_sync_q[15:0]);
              end else begin
                addr_q <= data_sync_q;
              end
              state_q <= HPP_ADDR_SET;
            end else if (!is_read && sel == HPP_SEL_CONTROL) begin
              control_q <= data_sync_q;
              state_q   <= HPP_IDLE;
            end else if (!is_read) begin
              host_ready_out <= 1'b0;
              fifo_valid_q   <= 1'b0;
              mem_req        <= 1'b1;
              mem_we         <= 1'b1;
              mem_wdata      <= data_sync_q;
              mem_addr       <= separate_address_enable_q ? hpp_page_addr(pins_sync_q) : addr_q;
              state_q        <= HPP_WRITE;
            end else begin
              state_q <= HPP_IDLE;
            end
          end
        end
        HPP_WRITE: begin
          if (mem_ack) begin
            mem_req        <= 1'b0;
            mem_we         <= 1'b0;
            host_ready_out <= 1'b1;
            if (sel == HPP_SEL_DATA_INC) addr_q <= addr_q + HPP_WORD_STEP;
            state_q <= HPP_IDLE;
          end
        end
        HPP_PREFETCH: begin
          if (mem_ack) begin
            mem_req        <= 1'b0;
            fifo_data_q    <= mem_rdata;
            fifo_valid_q   <= 1'b1;
            host_ready_out <= 1'b1;
            state_q        <= HPP_IDLE;
          end
        end
        HPP_ADDR_SET: begin
          host_ready_out <= 1'b1;
          state_q        <= HPP_IDLE;
        end
        default: state_q <= HPP_IDLE;
      endcase
    end
  end

endmodule : hpp_host_port

// file: tb/hpp_host_port_sva.sv
// Port-level checker for the host port page-address block.
// Bound to hpp_host_port; one clock, synchronous active-high reset.
`timescale 1ns/1ns
module hpp_host_port_sva (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        host_chip_select_n,
  input wire logic        host_data_bus_oe,
  input wire logic        host_ready_out,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  property p_resv; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_fetch_busy; mem_req && !mem_we && !mem_ack |=> !host_ready_out; endproperty
  a_fetch_busy: assert property (p_fetch_busy) else $error("ready high during fetch");
  property p_ack_ready; mem_req && mem_ack |=> host_ready_out; endproperty
  a_ack_ready: assert property (p_ack_ready) else $error("ready not back after answer");
  property p_req_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request not held");
  property p_idle_oe; host_chip_select_n [*6] |-> !host_data_bus_oe; endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("bus driven while deselected");
  property p_idle_req; host_chip_select_n [*8] |=> !$rose(mem_req); endproperty
  a_idle_req: assert property (p_idle_req) else $error("access while deselected");
endmodule : hpp_host_port_sva
////////////////////////////////////////
bind hpp_host_port hpp_host_port_sva hpp_host_port_sva_inst (.mclk, .reset, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .host_chip_select_n, .host_data_bus_oe,
  .host_ready_out, .mem_req, .mem_we, .mem_addr, .mem_ack);

// file: tb/hpp_mem_model.sv
// Internal memory responder behind the block's access port.
// Assumes requests are held until acknowledged; answers after dly cycles.
`timescale 1ns/1ns
module hpp_mem_model (
  input  wire logic        mclk,
  input  wire logic [3:0]  dly,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack = 1'b0,
  output logic [31:0]      mem_rdata = 32'h0,
  output int               req_cnt = 0,
  output logic [31:0]      last_addr = 32'h0
);
  int wait_q = 0;
  // Read data is the inverted address; between answers the lines keep flipping.
  always_ff @(posedge mclk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 1;
      if (wait_q == int'(dly)) begin
        mem_ack   <= 1'b1;
        mem_rdata <= ~mem_addr;
        wait_q    <= 0;
        req_cnt   <= req_cnt + 1;
        last_addr <= mem_addr;
      end
    end
  end
endmodule : hpp_mem_model

// file: tb/hpp_testbench.sv
// Self-checking bench for the host port page-address block.
// Drives AXI4-Lite and the host pins; a memory model answers the access port.
`timescale 1ns/1ns
module testbench;
  import hpp_pkg::*;
  logic        mclk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, host_chip_select_n;
  logic        host_address_strobe_n, host_halfword_select, host_read_write, host_data_bus_oe;
  logic        host_ready_out, mem_req, mem_we, mem_ack;
  logic [1:0]  s_axi_bresp, s_axi_rresp, host_data_strobe_n, host_register_select;
  logic [3:0]  s_axi_wstrb, dly;
  logic [15:0] host_address_pins;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, host_data_bus_in, host_data_bus_out;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, last_addr;
  int          req_cnt;
  int          errors = 0;
  int          compares = 0;
  hpp_host_port hpp_host_port_inst (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_chip_select_n,
    .host_data_strobe_n, .host_address_strobe_n, .host_register_select, .host_halfword_select, .host_read_write,
    .host_address_pins, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe, .host_ready_out, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  hpp_mem_model hpp_mem_model_inst (.mclk, .dly, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .req_cnt, .last_addr);
  ////////////////////////////////////////
  task automatic finish_test;
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic tmo;
    errors++;
    $display("mismatch %0t wait ran out", $time);
    finish_test();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
    chk(s_axi_bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : axi_rd
  task automatic rdy_wait(inout int lows);
    int n;
    for (n = 0; n < 80 && (n < 5 || host_ready_out !== 1'b1); n++) begin
      @(posedge mclk);
      lows += int'(host_ready_out !== 1'b1);
    end
    if (n == 80) tmo();
  endtask : rdy_wait
  // One host access; la and lb count not-ready cycles before and after the strobe rise.
  task automatic host(input logic [1:0] sel, input logic rd, input logic [31:0] d,
                      output logic [31:0] q, output int la, output int lb);
    la = 0;
    lb = 0;
    @(posedge mclk);
    {host_chip_select_n, host_register_select, host_read_write, host_data_bus_in} <= {1'b0, sel, rd, d};
    @(posedge mclk);
    host_data_strobe_n <= 2'b10;
    rdy_wait(la);
    q = host_data_bus_oe ? host_data_bus_out : 32'hx;
    {host_data_strobe_n, host_chip_select_n} <= 3'b111;
    rdy_wait(lb);
    host_data_bus_in <= ~d;
  endtask : host
  ////////////////////////////////////////
  task automatic t_regs;
    chk(host_ready_out, 1'b1);
    axi_rd(HPP_PAGE_TOP_OFFSET, 32'h0, HPP_RESP_OKAY);
    axi_rd(HPP_PAGE_MID_OFFSET, 32'h0, HPP_RESP_OKAY);
    axi_rd(32'h40000014, 32'h0, HPP_RESP_SLVERR);
    axi_wr(32'h40000014, 32'h1, HPP_RESP_SLVERR);
    axi_wr(HPP_PAGE_TOP_OFFSET, 32'hab, HPP_RESP_OKAY);
    axi_wr(HPP_PAGE_MID_OFFSET, 32'hcd, HPP_RESP_OKAY);
    axi_rd(HPP_PAGE_TOP_OFFSET, 32'hab, HPP_RESP_OKAY);
    axi_rd(HPP_PAGE_MID_OFFSET, 32'hcd, HPP_RESP_OKAY);
  endtask : t_regs
  task automatic t_sep;
    logic [31:0] q;
    int          la, lb;
    axi_wr(HPP_CFG_OFFSET, 32'h1 << HPP_CFG_SEPARATE_POS, HPP_RESP_OKAY);
    host_address_pins <= 16'h1234;
    host(HPP_SEL_DATA_HOLD, 1'b0, 32'h600dcafe, q, la, lb);
    chk(last_addr[31:24], 8'hab);
    chk(last_addr[23:0], 24'hcd1234);
    chk(mem_wdata, 32'h600dcafe);
    chk(lb > 0, 1'b1);
  endtask : t_sep
  task automatic t_page;
    logic [31:0] q;
    int          la, lb, c;
    axi_wr(HPP_CFG_OFFSET, 32'h1 << HPP_CFG_PAGING_POS, HPP_RESP_OKAY);
    host(HPP_SEL_ADDRESS, 1'b0, 32'h77770040, q, la, lb);
    chk(lb > 0, 1'b1);
    c = req_cnt;
    host(HPP_SEL_DATA_INC, 1'b1, 32'h0, q, la, lb);
    chk(q, ~32'habcd0040);
    chk(la > 0 && lb > 0, 1'b1);
    chk(req_cnt - c, 2);
    host(HPP_SEL_DATA_INC, 1'b1, 32'h0, q, la, lb);
    chk(q, ~(32'habcd0040 + HPP_WORD_STEP));
    chk(la, 0);
    chk(lb > 0, 1'b1);
    host(HPP_SEL_CONTROL, 1'b0, 32'h0000a5c3, q, la, lb);
    c = req_cnt;
    host(HPP_SEL_CONTROL, 1'b1, 32'h0, q, la, lb);
    chk(la + lb, 0);
    chk(q, 32'h0000a5c3);
    host(HPP_SEL_ADDRESS, 1'b1, 32'h0, q, la, lb);
    chk(la + lb + req_cnt - c, 0);
    chk(q, 32'habcd0048);
    // Controls latched at the address strobe fall must win over later pin values.
    host_register_select  <= HPP_SEL_CONTROL;
    host_read_write       <= 1'b1;
    host_address_strobe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    host(HPP_SEL_DATA_HOLD, 1'b1, 32'h0, q, la, lb);
    chk(la + lb + req_cnt - c, 0);
    chk(q, 32'h0000a5c3);
    host_address_strobe_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : t_page
  task automatic t_full;
    logic [31:0] q;
    int          la, lb;
    dly <= 4'hc;
    axi_wr(HPP_CFG_OFFSET, 32'h0, HPP_RESP_OKAY);
    host(HPP_SEL_ADDRESS, 1'b0, 32'h12345678, q, la, lb);
    host(HPP_SEL_DATA_HOLD, 1'b1, 32'h0, q, la, lb);
    chk(q, ~32'h12345678);
    chk(la > 12, 1'b1);
  endtask : t_full
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    reset = 1'b1;
    dly = 4'h4;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, host_data_bus_in} = '0;
    {host_chip_select_n, host_data_strobe_n, host_address_strobe_n} = '1;
    {host_register_select, host_halfword_select, host_read_write, host_address_pins} = '0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_sep();
    t_page();
    t_full();
    finish_test();
  end
endmodule : testbench
